// ===== mdc_defines.svh
// Constants for the mesh delivery control block.
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define MDC_OFF_CTRL      6'h00
`define MDC_OFF_STATUS    6'h04
`define MDC_OFF_DEST_UP   6'h08
`define MDC_OFF_DEST_LO   6'h0C
`define MDC_OFF_OWN_UP    6'h10
`define MDC_OFF_OWN_LO    6'h14
`define MDC_OFF_ATTEMPT   6'h18
`define MDC_OFF_SLOTS     6'h1C
`define MDC_OFF_DISC      6'h20
`define MDC_OFF_HOPS      6'h24
`define MDC_OFF_POWER     6'h28
`define MDC_OFF_NETKEY    6'h2C
`define MDC_OFF_ROUTE     6'h30
`define MDC_OFF_EVENT     6'h34
// ----------------------------------------------------------------
// Ranges and defaults
// ----------------------------------------------------------------
`define MDC_ATTEMPT_MAX   8'h0FF
`define MDC_ATTEMPT_DEF   8'h01
`define MDC_SLOTS_MAX     8'h10
`define MDC_SLOTS_DEF     8'h03
`define MDC_DISC_MAX      8'h0A
`define MDC_DISC_DEF      8'h03
`define MDC_HOPS_DEF      8'h07
`define MDC_POWER_MAX     8'h04
`define MDC_POWER_DEF     8'h04
`define MDC_NETKEY_MIN    16'h0010
`define MDC_NETKEY_MAX    16'h7FFF
`define MDC_NETKEY_DEF    16'h3332
`define MDC_BCAST_UP      32'h0000_0000
`define MDC_BCAST_LO      32'h0000_FFFF
`define MDC_BCAST_SENDS   3'h4
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MDC_CLK_HZ        50000000
`define MDC_SLOT_MS       168
`define MDC_SLOT_CYC      ((`MDC_CLK_HZ / 1000) * `MDC_SLOT_MS)
`define MDC_HOP_US        1000
`define MDC_HOP_CYC       ((`MDC_CLK_HZ / 1000000) * `MDC_HOP_US)
// ----------------------------------------------------------------
// Control bits
// ----------------------------------------------------------------
`define MDC_CTRL_SEND     0
`define MDC_CTRL_COMMIT   1
`define MDC_CTRL_USERDEF  2
`define MDC_CTRL_FACTDEF  3
`define MDC_CTRL_RESTART  4
`define MDC_CTRL_CMDON    5
`define MDC_CTRL_CMDOFF   6
`endif

// ===== mdc_peer.sv
// Behavioural peer node that answers the block across the radio side.
`timescale 1ns/1ps
module mdc_peer
	import mdc_pkg::*;
#(
	parameter logic [63:0] ADDR = 64'h0000_0001_0000_0042,
	parameter logic [15:0] KEY  = 16'h3332
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire mdc_pkg::mdc_pkt_t tx_pkt,
	input  wire logic [15:0]       tx_key,
	input  wire logic              mute,
	input  wire logic [3:0]        lat,
	input  wire mdc_pkg::mdc_pkt_t inj,
	input  wire logic [15:0]       inj_key,
	output mdc_pkg::mdc_pkt_t      rx_pkt,
	output logic [15:0]            rx_key
);
	import mdc_pkg::*;
	mdc_pkt_t   pend;
	logic [3:0] cnt;
	logic       hit;

	// ----------------------------------------------------------------
	// Answers
	// ----------------------------------------------------------------
	// A foreign key means the packet is not ours to answer at all.
	assign hit = tx_pkt.valid && !mute && tx_key == KEY;

	// One pending answer is enough: the block waits for each one.
	always_ff @(posedge clock) begin
		if (rst) begin
			pend <= '0;
			cnt  <= '0;
		end else if (hit && tx_pkt.kind == MDC_K_DATA && tx_pkt.dst == ADDR) begin
			pend <= '{valid:1'b1, kind:MDC_K_ACK, src:ADDR, dst:tx_pkt.src,
				seq:tx_pkt.seq, quality:8'h00};
			cnt  <= lat;
		end else if (hit && tx_pkt.kind == MDC_K_REQ) begin
			pend <= '{valid:1'b1, kind:MDC_K_REPLY, src:ADDR, dst:tx_pkt.src,
				seq:tx_pkt.seq, quality:8'h40};
			cnt  <= lat;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else begin
			pend.valid <= 1'b0;
		end
	end

	// The bench's injected packets take priority over our own answers.
	assign rx_pkt = inj.valid ? inj : (cnt == 4'h0 ? pend : '0);
	assign rx_key = inj.valid ? inj_key : KEY;
endmodule

// ===== mdc_pkg.sv
// Types for the mesh delivery control block.
package mdc_pkg;
	typedef enum logic [2:0] {
		MDC_IDLE  = 3'b000,
		MDC_SEND  = 3'b001,
		MDC_WAIT  = 3'b011,
		MDC_DISC  = 3'b010,
		MDC_RELAY = 3'b110,
		MDC_GAP   = 3'b111
	} mdc_state_t;
	typedef struct packed {
		logic        valid;
		logic [3:0]  kind;
		logic [63:0] src;
		logic [63:0] dst;
		logic [15:0] seq;
		logic [7:0]  quality;
	} mdc_pkt_t;
	// Packet kinds on the radio side.
	localparam logic [3:0] MDC_K_DATA  = 4'h0;
	localparam logic [3:0] MDC_K_ACK   = 4'h1;
	localparam logic [3:0] MDC_K_BCAST = 4'h2;
	localparam logic [3:0] MDC_K_REQ   = 4'h3;
	localparam logic [3:0] MDC_K_REPLY = 4'h4;
endpackage

// ===== mdc_top.sv
// Mesh delivery control: retries, broadcast relay, routing, config regs.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "mdc_defines.svh"
module mdc_top #(
	parameter int unsigned SLOT_CYC = `MDC_SLOT_CYC,
	parameter int unsigned HOP_CYC  = `MDC_HOP_CYC,
	parameter logic [31:0] OWN_UP   = 32'h0000_0001, // Arbitrary value.
	parameter logic [31:0] OWN_LO   = 32'h0000_0001
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [5:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	output logic      [1:0]        avs_response,
	input  wire mdc_pkg::mdc_pkt_t rx_pkt,
	input  wire logic [15:0]       rx_key,
	output mdc_pkg::mdc_pkt_t      tx_pkt,
	output logic      [15:0]       tx_key,
	output logic      [2:0]        tx_power,
	output logic                   ack_req,
	output logic                   cmd_state,
	output logic                   commit_pulse,
	output logic                   restart_pulse
);
	import mdc_pkg::*;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [31:0] dest_up, dest_lo;
	logic [7:0]  attempt_lim, slot_lim, disc_lim, hop_est;
	logic [2:0]  power_sel;
	logic [15:0] net_key;
	logic        ack_phase, bad_val;
	logic        wr_hit, rd_hit, send_req;
	logic [63:0] rt_dst, rt_hop;
	logic        rt_valid, rt_failed;
	logic [7:0]  rt_qual, fail_count;

	assign wr_hit = avs_write && !ack_phase;
	assign rd_hit = avs_read && !ack_phase;

	// Range check on a write; bad values are refused and answer SLVERR.
	always_comb begin
		bad_val = 1'b0;
		case (avs_address)
		`MDC_OFF_ATTEMPT: bad_val = avs_writedata > 32'(`MDC_ATTEMPT_MAX);
		`MDC_OFF_SLOTS:   bad_val = avs_writedata > 32'(`MDC_SLOTS_MAX);
		`MDC_OFF_DISC:    bad_val = avs_writedata > 32'(`MDC_DISC_MAX);
		`MDC_OFF_HOPS:    bad_val = avs_writedata > 32'h0000_00FF;
		`MDC_OFF_POWER:   bad_val = avs_writedata > 32'(`MDC_POWER_MAX);
		`MDC_OFF_NETKEY:  bad_val = avs_writedata < 32'(`MDC_NETKEY_MIN) ||
			avs_writedata > 32'(`MDC_NETKEY_MAX);
		`MDC_OFF_OWN_UP, `MDC_OFF_OWN_LO:
			bad_val = 1'b1;
		default:          bad_val = 1'b0;
		endcase
	end

	// Every access takes two cycles; waitrequest idles high, drops to answer.
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_phase    <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_response <= 2'b00;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_phase <= (avs_read || avs_write) && !ack_phase;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_phase);
			if (rd_hit) begin
				avs_response <= 2'b00;
				case (avs_address)
				`MDC_OFF_STATUS:  avs_readdata <= {28'h000_0000,
					cmd_state, rt_failed, rt_valid, send_req};
				`MDC_OFF_DEST_UP: avs_readdata <= dest_up;
				`MDC_OFF_DEST_LO: avs_readdata <= dest_lo;
				`MDC_OFF_OWN_UP:  avs_readdata <= OWN_UP;
				`MDC_OFF_OWN_LO:  avs_readdata <= OWN_LO;
				`MDC_OFF_ATTEMPT: avs_readdata <= {24'h00_0000, attempt_lim};
				`MDC_OFF_SLOTS:   avs_readdata <= {24'h00_0000, slot_lim};
				`MDC_OFF_DISC:    avs_readdata <= {24'h00_0000, disc_lim};
				`MDC_OFF_HOPS:    avs_readdata <= {24'h00_0000, hop_est};
				`MDC_OFF_POWER:   avs_readdata <= {29'h0000_0000, power_sel};
				`MDC_OFF_NETKEY:  avs_readdata <= {16'h0000, net_key};
				`MDC_OFF_ROUTE:   avs_readdata <= rt_hop[31:0];
				`MDC_OFF_EVENT:   avs_readdata <= {24'h00_0000, fail_count};
				default: begin
					avs_readdata <= 32'h0000_0000;
					avs_response <= 2'b11;
				end
				endcase
			end else if (wr_hit) begin
				avs_response <= bad_val ? 2'b10 : 2'b00;
			end
		end
	end

	// Parameter store; the default loads double as factory and user sets.
	always_ff @(posedge clock) begin
		if (rst || (wr_hit && !avs_address[5] && avs_address[4:0] == 5'h00 &&
		    (avs_writedata[`MDC_CTRL_FACTDEF] ||
		     avs_writedata[`MDC_CTRL_USERDEF]))) begin
			dest_up     <= `MDC_BCAST_UP;
			dest_lo     <= `MDC_BCAST_LO;
			attempt_lim <= `MDC_ATTEMPT_DEF;
			slot_lim    <= `MDC_SLOTS_DEF;
			disc_lim    <= `MDC_DISC_DEF;
			hop_est     <= `MDC_HOPS_DEF;
			power_sel   <= 3'(`MDC_POWER_DEF);
			net_key     <= `MDC_NETKEY_DEF;
		end else if (wr_hit && !bad_val) begin
			case (avs_address)
			`MDC_OFF_DEST_UP: dest_up     <= avs_writedata;
			`MDC_OFF_DEST_LO: dest_lo     <= avs_writedata;
			`MDC_OFF_ATTEMPT: attempt_lim <= avs_writedata[7:0];
			`MDC_OFF_SLOTS:   slot_lim    <= avs_writedata[7:0];
			`MDC_OFF_DISC:    disc_lim    <= avs_writedata[7:0];
			`MDC_OFF_HOPS:    hop_est     <= avs_writedata[7:0];
			`MDC_OFF_POWER:   power_sel   <= avs_writedata[2:0];
			`MDC_OFF_NETKEY:  net_key     <= avs_writedata[15:0];
			default: ;
			endcase
		end
	end

	// Control strobes from the control register.
	logic ctrl_wr;
	assign ctrl_wr = wr_hit && avs_address == `MDC_OFF_CTRL;
	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_state     <= 1'b0;
			commit_pulse  <= 1'b0;
			restart_pulse <= 1'b0;
		end else begin
			commit_pulse  <= ctrl_wr && avs_writedata[`MDC_CTRL_COMMIT];
			restart_pulse <= ctrl_wr && avs_writedata[`MDC_CTRL_RESTART];
			if (ctrl_wr && avs_writedata[`MDC_CTRL_CMDON])
				cmd_state <= 1'b1;
			else if (ctrl_wr && avs_writedata[`MDC_CTRL_CMDOFF])
				cmd_state <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Delivery engine
	// ------------------------------------------------------------
	mdc_state_t  state;
	logic [63:0] cur_dst;
	logic [8:0]  tries;
	logic [7:0]  disc_tries;
	logic [31:0] timer;
	logic [2:0]  sends;
	logic [15:0] seq, lfsr, relay_seq;
	logic [63:0] relay_src, dup_src;
	logic [15:0] dup_seq;
	logic        dup_valid;
	logic        key_ok, is_bcast, rx_dup;
	logic [31:0] ack_wait;

	assign key_ok   = rx_pkt.valid && rx_key == net_key;
	assign is_bcast = cur_dst == {`MDC_BCAST_UP, `MDC_BCAST_LO};
	assign rx_dup   = dup_valid && dup_src == rx_pkt.src &&
		dup_seq == rx_pkt.seq;
	// Two crossings of hop_estimate hops each.
	assign ack_wait = 32'(2 * HOP_CYC) * {24'h00_0000, hop_est};

	always_ff @(posedge clock) begin
		if (rst) lfsr <= 16'hACE1;
		else lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	end

	// Send requests latch until the engine takes them.
	always_ff @(posedge clock) begin
		if (rst) send_req <= 1'b0;
		else if (ctrl_wr && avs_writedata[`MDC_CTRL_SEND]) send_req <= 1'b1;
		else if (state == MDC_IDLE && !rx_pkt.valid) send_req <= 1'b0;
	end

	// Route table of one entry: destination to next hop with quality.
	always_ff @(posedge clock) begin
		if (rst) begin
			rt_valid <= 1'b0;
			rt_dst   <= 64'h0000_0000_0000_0000;
			rt_hop   <= 64'h0000_0000_0000_0000;
			rt_qual  <= 8'h00;
		end else if (state == MDC_WAIT && timer == 32'h0000_0000 &&
		             tries > {1'b0, attempt_lim} && !is_bcast) begin
			rt_valid <= 1'b0;
		end else if (key_ok && rx_pkt.kind == MDC_K_REPLY &&
		             rx_pkt.dst == {OWN_UP, OWN_LO} &&
		             (!rt_valid || rt_dst != rx_pkt.src ||
		              rx_pkt.quality > rt_qual)) begin
			rt_valid <= 1'b1;
			rt_dst   <= rx_pkt.src;
			rt_hop   <= rx_pkt.src;
			rt_qual  <= rx_pkt.quality;
		end
	end

	// Main state machine: unicast with retries, broadcast, discovery.
	always_ff @(posedge clock) begin
		if (rst) begin
			state      <= MDC_IDLE;
			tx_pkt     <= '0;
			tries      <= 9'h000;
			disc_tries <= 8'h00;
			timer      <= 32'h0000_0000;
			sends      <= 3'h0;
			seq        <= 16'h0000;
			cur_dst    <= 64'h0000_0000_0000_0000;
			rt_failed  <= 1'b0;
			fail_count <= 8'h00;
			dup_valid  <= 1'b0;
			dup_src    <= 64'h0000_0000_0000_0000;
			dup_seq    <= 16'h0000;
			relay_src  <= 64'h0000_0000_0000_0000;
			relay_seq  <= 16'h0000;
			ack_req    <= 1'b0;
		end else begin
			tx_pkt.valid <= 1'b0;
			case (state)
			MDC_IDLE: begin
				if (key_ok && (rx_pkt.kind == MDC_K_BCAST ||
				    rx_pkt.kind == MDC_K_REQ) && !rx_dup &&
				    rx_pkt.src != {OWN_UP, OWN_LO}) begin
					dup_valid <= 1'b1;
					dup_src   <= rx_pkt.src;
					dup_seq   <= rx_pkt.seq;
					if (rx_pkt.kind == MDC_K_REQ &&
					    rx_pkt.dst == {OWN_UP, OWN_LO}) begin
						tx_pkt <= '{1'b1, MDC_K_REPLY, {OWN_UP, OWN_LO},
							rx_pkt.src, rx_pkt.seq, rx_pkt.quality};
					end else begin
						relay_src <= rx_pkt.src;
						relay_seq <= rx_pkt.seq;
						sends     <= `MDC_BCAST_SENDS;
						timer     <= SLOT_CYC *
							(32'(lfsr[4:0]) % (32'(slot_lim) + 1));
						state     <= MDC_RELAY;
					end
				end else if (key_ok && rx_pkt.kind == MDC_K_REQ &&
				    rx_pkt.dst == {OWN_UP, OWN_LO}) begin
					tx_pkt <= '{1'b1, MDC_K_REPLY, {OWN_UP, OWN_LO},
						rx_pkt.src, rx_pkt.seq, rx_pkt.quality};
				end else if (key_ok && rx_pkt.kind == MDC_K_DATA &&
				    rx_pkt.dst == {OWN_UP, OWN_LO}) begin
					tx_pkt <= '{1'b1, MDC_K_ACK, {OWN_UP, OWN_LO},
						rx_pkt.src, rx_pkt.seq, 8'h00};
				end else if (send_req && !rx_pkt.valid) begin
					cur_dst    <= {dest_up, dest_lo};
					seq        <= seq + 16'h0001;
					tries      <= 9'h000;
					disc_tries <= 8'h00;
					rt_failed  <= 1'b0;
					sends      <= `MDC_BCAST_SENDS;
					state      <= MDC_SEND;
				end
			end
			MDC_SEND: begin
				if (is_bcast) begin
					tx_pkt <= '{1'b1, MDC_K_BCAST, {OWN_UP, OWN_LO},
						cur_dst, seq, 8'h00};
					sends  <= sends - 3'h1;
					if (sends == 3'h1) state <= MDC_IDLE;
				end else if (!rt_valid || rt_dst != cur_dst) begin
					tx_pkt <= '{1'b1, MDC_K_REQ, {OWN_UP, OWN_LO},
						cur_dst, seq, 8'h00};
					timer  <= ack_wait;
					state  <= MDC_DISC;
				end else begin
					tx_pkt <= '{1'b1, MDC_K_DATA, {OWN_UP, OWN_LO},
						rt_hop, seq, 8'h00};
					ack_req <= attempt_lim != 8'h00;
					tries  <= tries + 9'h001;
					timer  <= ack_wait;
					state  <= MDC_WAIT;
				end
			end
			MDC_WAIT: begin
				timer <= timer - 32'h0000_0001;
				if (key_ok && rx_pkt.kind == MDC_K_ACK &&
				    rx_pkt.seq == seq) begin
					state <= MDC_IDLE;
				end else if (timer == 32'h0000_0000) begin
					if (attempt_lim == 8'h00) state <= MDC_IDLE;
					else if (tries > {1'b0, attempt_lim}) begin
						rt_failed  <= 1'b1;
						fail_count <= fail_count + 8'h01;
						tries      <= 9'h000;
						state      <= MDC_SEND;
					end else state <= MDC_SEND;
				end
			end
			MDC_DISC: begin
				timer <= timer - 32'h0000_0001;
				if (rt_valid && rt_dst == cur_dst) state <= MDC_SEND;
				else if (timer == 32'h0000_0000) begin
					if (disc_tries >= disc_lim) state <= MDC_IDLE;
					else begin
						disc_tries <= disc_tries + 8'h01;
						state      <= MDC_SEND;
					end
				end
			end
			MDC_RELAY: begin
				timer <= timer - 32'h0000_0001;
				if (timer == 32'h0000_0000) begin
					tx_pkt <= '{1'b1, MDC_K_BCAST, relay_src,
						{`MDC_BCAST_UP, `MDC_BCAST_LO}, relay_seq, 8'h00};
					// Reload so each repeat waits its own random delay.
					timer  <= SLOT_CYC *
						(32'(lfsr[4:0]) % (32'(slot_lim) + 1));
					sends  <= sends - 3'h1;
					state  <= (sends == 3'h1) ? MDC_IDLE : MDC_GAP;
				end
			end
			MDC_GAP: state <= MDC_RELAY;
			default: state <= MDC_IDLE;
			endcase
		end
	end

	// Link side copies of the configuration.
	always_ff @(posedge clock) begin
		if (rst) begin
			tx_key   <= `MDC_NETKEY_DEF;
			tx_power <= 3'(`MDC_POWER_DEF);
		end else begin
			tx_key   <= net_key;
			tx_power <= power_sel;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_bad_write_kept: assert property (@(posedge clock) disable iff (rst)
		wr_hit && bad_val && avs_address == `MDC_OFF_POWER |=>
		$stable(power_sel) && avs_response == 2'b10)
		else $error("Out of range write changed a value.");
	chk_ack_answer: assert property (@(posedge clock) disable iff (rst)
		state == MDC_IDLE && key_ok && rx_pkt.kind == MDC_K_DATA &&
		rx_pkt.dst == {OWN_UP, OWN_LO} && !send_req |=>
		tx_pkt.valid && tx_pkt.kind == MDC_K_ACK)
		else $error("No ack for a received unicast.");
	chk_bcast_kind: assert property (@(posedge clock) disable iff (rst)
		state == MDC_SEND && is_bcast |=> tx_pkt.kind == MDC_K_BCAST)
		else $error("Broadcast destination sent as unicast.");
	chk_no_route_req: assert property (@(posedge clock) disable iff (rst)
		state == MDC_SEND && !is_bcast && !rt_valid |=>
		state == MDC_DISC && tx_pkt.kind == MDC_K_REQ)
		else $error("Unrouted packet sent without path_request.");
	chk_wait_timer: assert property (@(posedge clock) disable iff (rst)
		state == MDC_SEND && !is_bcast && rt_valid && rt_dst == cur_dst |=>
		state == MDC_WAIT && timer == ack_wait)
		else $error("Ack wait not loaded.");
	chk_ack_request: assert property (@(posedge clock) disable iff (rst)
		state == MDC_WAIT |-> ack_req == (attempt_lim != 8'h00))
		else $error("Ack request flag wrong.");
	chk_try_bound: assert property (@(posedge clock) disable iff (rst)
		state == MDC_WAIT |-> tries <= {1'b0, attempt_lim} + 9'h001)
		else $error("Too many delivery attempts.");
	chk_relay_delay: assert property (@(posedge clock) disable iff (rst)
		state == MDC_RELAY && $past(state) == MDC_IDLE |->
		timer <= SLOT_CYC * 32'(slot_lim))
		else $error("Relay delay beyond slot limit.");
	chk_power_out: assert property (@(posedge clock) disable iff (rst)
		##1 tx_power == $past(power_sel))
		else $error("Power output not following select.");
endmodule

// ===== tb.sv
// Self-checking testbench for the mesh delivery control block.
`timescale 1ns/1ps
`include "mdc_defines.svh"
module tb;
	import mdc_pkg::*;
	localparam logic [63:0] PEER = 64'h0000_0001_0000_0042;
	localparam logic [63:0] SELF = 64'h0000_0001_0000_0001;
	localparam logic [63:0] BCST = 64'h0000_0000_0000_FFFF;
	logic        clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic        avs_waitrequest, ack_req, cmd_state, commit_pulse;
	logic        restart_pulse, mute = 1'b0;
	logic [5:0]  avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd;
	logic [1:0]  avs_response, rr;
	logic [15:0] rx_key, tx_key, inj_key = 16'h3332;
	logic [2:0]  tx_power;
	logic [3:0]  lat = 4'h5;
	mdc_pkt_t    rx_pkt, tx_pkt, inj = '0;
	int          fails = 0, n_compared = 0, cycles = 0, n_data = 0, n_req = 0;
	int          n_bcast = 0, n_commit = 0, n_restart = 0;
	int          n_ack = 0, n_reply = 0;
	logic [5:0]  offs [8] = '{`MDC_OFF_ATTEMPT, `MDC_OFF_SLOTS, `MDC_OFF_DISC,
		`MDC_OFF_HOPS, `MDC_OFF_POWER, `MDC_OFF_NETKEY, `MDC_OFF_DEST_UP,
		`MDC_OFF_DEST_LO};
	logic [31:0] dflt [8] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0003,
		32'h0000_0007, 32'h0000_0004, 32'h0000_3332, 32'h0000_0000,
		32'h0000_FFFF};
	logic [5:0]  bo [6] = '{`MDC_OFF_POWER, `MDC_OFF_SLOTS, `MDC_OFF_DISC,
		`MDC_OFF_NETKEY, `MDC_OFF_NETKEY, `MDC_OFF_OWN_UP};
	logic [31:0] bv [6] = '{32'h0000_0005, 32'h0000_0011, 32'h0000_000B,
		32'h0000_000F, 32'h0000_8000, 32'h0000_0000};
	logic [31:0] bk [6] = '{32'h0000_0004, 32'h0000_0003, 32'h0000_0003,
		32'h0000_3332, 32'h0000_3332, 32'h0000_0001};

	// ----------------------------------------------------------------
	// Design, peer and clock
	// ----------------------------------------------------------------
	// Short slot and hop counts keep relay and ack waits to a few cycles.
	mdc_top #(.SLOT_CYC(4), .HOP_CYC(2), .OWN_UP(32'h0000_0001),
		.OWN_LO(32'h0000_0001)) mdc_top_inst (.clock(clock), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .rx_pkt(rx_pkt), .rx_key(rx_key),
		.tx_pkt(tx_pkt), .tx_key(tx_key), .tx_power(tx_power),
		.ack_req(ack_req), .cmd_state(cmd_state),
		.commit_pulse(commit_pulse), .restart_pulse(restart_pulse));
	mdc_peer #(.ADDR(PEER), .KEY(16'h3332)) mdc_peer_inst (.clock(clock),
		.rst(rst), .tx_pkt(tx_pkt), .tx_key(tx_key), .mute(mute),
		.lat(lat), .inj(inj), .inj_key(inj_key), .rx_pkt(rx_pkt),
		.rx_key(rx_key));
	always #10 clock = ~clock;

	// Count what leaves the block and cut a hang short.
	always @(posedge clock) begin
		cycles++;
		if (tx_pkt.valid === 1'b1 && tx_pkt.kind === MDC_K_DATA) n_data++;
		if (tx_pkt.valid === 1'b1 && tx_pkt.kind === MDC_K_REQ) n_req++;
		if (tx_pkt.valid === 1'b1 && tx_pkt.kind === MDC_K_BCAST) n_bcast++;
		if (tx_pkt.valid === 1'b1 && tx_pkt.kind === MDC_K_ACK) n_ack++;
		if (tx_pkt.valid === 1'b1 && tx_pkt.kind === MDC_K_REPLY) n_reply++;
		if (commit_pulse === 1'b1) n_commit++;
		if (restart_pulse === 1'b1) n_restart++;
		if (cycles == 60000) begin
			fails++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// The request is held until waitrequest is seen low, then taken.
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clock);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rr = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wait_cnt(ref int c, input int t);
		int k;
		k = 0;
		while (c < t && k < 3000) begin
			@(posedge clock);
			k++;
		end
	endtask

	task automatic inject(input logic [3:0] k, input logic [63:0] d,
		input logic [15:0] s, input logic [15:0] key);
		@(posedge clock);
		inj <= '{valid:1'b1, kind:k, src:64'h0000_0000_0000_0077,
			dst:d, seq:s, quality:8'h00};
		inj_key <= key;
		@(posedge clock);
		inj.valid <= 1'b0;
		repeat (600) @(posedge clock);
	endtask

	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		foreach (offs[i]) begin
			bus(1'b0, offs[i], '0);
			check("reset value", rd, dflt[i]);
		end
		check("tx_key", {16'h0000, tx_key}, 32'h0000_3332);
		$display("test defaults done");
		foreach (bo[i]) begin
			bus(1'b1, bo[i], bv[i]);
			check("refused response", {30'h0, rr}, 32'h0000_0002);
			bus(1'b0, bo[i], '0);
			check("kept value", rd, bk[i]);
		end
		bus(1'b0, 6'h3C, '0);
		check("unmapped response", {30'h0, rr}, 32'h0000_0003);
		bus(1'b1, `MDC_OFF_SLOTS, 32'h0000_0010);
		check("slot limit response", {30'h0, rr}, 32'h0000_0000);
		$display("test refusals done");
		// A relay happens four times, not again for a repeat of the last message seen.
		inject(MDC_K_BCAST, BCST, 16'h0055, 16'h3332);
		check("relay count", n_bcast, 32'h0000_0004);
		inject(MDC_K_BCAST, BCST, 16'h0055, 16'h3332);
		check("duplicate relays", n_bcast, 32'h0000_0004);
		inject(MDC_K_BCAST, BCST, 16'h0056, 16'h1234);
		check("foreign key relays", n_bcast, 32'h0000_0004);
		// Data and requests addressed here are answered every time.
		inject(MDC_K_DATA, SELF, 16'h0057, 16'h3332);
		check("acks sent", n_ack, 32'h0000_0001);
		inject(MDC_K_REQ, SELF, 16'h0058, 16'h3332);
		inject(MDC_K_REQ, SELF, 16'h0058, 16'h3332);
		check("replies sent", n_reply, 32'h0000_0002);
		$display("test broadcast done");
		bus(1'b1, `MDC_OFF_DEST_UP, PEER[63:32]);
		bus(1'b1, `MDC_OFF_DEST_LO, PEER[31:0]);
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0001);
		wait_cnt(n_data, 1);
		check("requests before data", n_req, 32'h0000_0001);
		check("ack requested", {31'h0, ack_req}, 32'h0000_0001);
		repeat (300) @(posedge clock);
		check("acked sends", n_data, 32'h0000_0001);
		bus(1'b0, `MDC_OFF_ROUTE, '0);
		check("next hop", rd, PEER[31:0]);
		// A silent peer uses up both attempts and fails the route.
		bus(1'b1, `MDC_OFF_DISC, 32'h0000_0000);
		mute <= 1'b1;
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0001);
		wait_cnt(n_data, 3);
		repeat (1500) @(posedge clock);
		check("unacked sends", n_data, 32'h0000_0003);
		check("rediscovery", n_req, 32'h0000_0002);
		bus(1'b0, `MDC_OFF_EVENT, '0);
		check("route failures", rd, 32'h0000_0001);
		bus(1'b0, `MDC_OFF_STATUS, '0);
		check("status after failure", rd, 32'h0000_0004);
		$display("test unicast done");
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0020);
		repeat (2) @(posedge clock);
		check("command state", {31'h0, cmd_state}, 32'h0000_0001);
		for (int p = 0; p < 5; p++) begin
			bus(1'b1, `MDC_OFF_POWER, p);
			repeat (2) @(posedge clock);
			check("tx_power", {29'h0, tx_power}, p);
		end
		bus(1'b1, `MDC_OFF_POWER, 32'h0000_0001);
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0008);
		bus(1'b0, `MDC_OFF_POWER, '0);
		check("factory power", rd, 32'h0000_0004);
		bus(1'b1, `MDC_OFF_POWER, 32'h0000_0002);
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0004);
		bus(1'b0, `MDC_OFF_POWER, '0);
		check("user power", rd, 32'h0000_0004);
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0040);
		repeat (2) @(posedge clock);
		check("left command", {31'h0, cmd_state}, 32'h0000_0000);
		// Defaults point at broadcast, so a send originates four copies.
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0001);
		repeat (20) @(posedge clock);
		check("origin broadcasts", n_bcast, 32'h0000_0008);
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0002);
		bus(1'b1, `MDC_OFF_CTRL, 32'h0000_0010);
		repeat (2) @(posedge clock);
		check("commit pulses", n_commit, 32'h0000_0001);
		check("restart pulses", n_restart, 32'h0000_0001);
		$display("test commands done");
		finish_test();
	end
endmodule
